// file: core/dcke_cfg.svh
`ifndef DCKE_CFG_SVH
`define DCKE_CFG_SVH

// Address pin positions and address width
`define DCKE_A10            10
`define DCKE_A12            12
`define DCKE_ADDR_W         14

// Mode register 0 burst field and its encodings
`define DCKE_MR0_BL_LSB     0
`define DCKE_BL_FIXED8      2'h0
`define DCKE_BL_OTF         2'h1
`define DCKE_BL_FIXED4      2'h2

// Timer width in bits, then timing counts in mclk cycles
`define DCKE_TIMER_W        10
`define DCKE_BL8_CYC        4
`define DCKE_BC4_CYC        2
`define DCKE_T_RP_CYC       3
`define DCKE_T_RFC_CYC      8
`define DCKE_T_XP_CYC       3
`define DCKE_T_CKE_CYC      3
`define DCKE_ZQINIT_CYC     512
`define DCKE_ZQOPER_CYC     256
`define DCKE_ZQCS_CYC       64

`endif

// file: core/dcke_pkg.sv
`default_nettype none

package dcke_pkg;

    typedef enum logic [3:0] {
        CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP, CMD_DES
    } dcke_cmd_e;

    typedef enum logic [2:0] {
        PW_ON, PW_APD, PW_PPD, PW_PD, PW_SR
    } dcke_pwr_e;

    // Pin pattern {cs_n, ras_n, cas_n, we_n} to command
    function automatic dcke_cmd_e dcke_decode(input logic [3:0] pins);
        dcke_cmd_e c;
        c = CMD_DES;
        if (!pins[3]) begin
            unique case (pins[2:0])
                3'h0: c = CMD_MRS;
                3'h1: c = CMD_REF;
                3'h2: c = CMD_PRE;
                3'h3: c = CMD_ACT;
                3'h4: c = CMD_WR;
                3'h5: c = CMD_RD;
                3'h6: c = CMD_ZQ;
                3'h7: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [3:0] dcke_encode(input dcke_cmd_e c);
        logic [3:0] p;
        p = 4'h8;
        unique case (c)
            CMD_MRS: p = 4'h0;
            CMD_REF: p = 4'h1;
            CMD_PRE: p = 4'h2;
            CMD_ACT: p = 4'h3;
            CMD_WR:  p = 4'h4;
            CMD_RD:  p = 4'h5;
            CMD_ZQ:  p = 4'h6;
            CMD_NOP: p = 4'h7;
            CMD_DES: p = 4'h8;
        endcase
        return p;
    endfunction

endpackage

`default_nettype wire

// file: core/dcke_if.sv
`default_nettype none

interface dcke_if #(parameter int AW = 14);
    logic          reset_n;
    logic          cke;
    logic          cs_n;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic          odt;
    logic [2:0]    ba;
    logic [AW-1:0] addr;

    modport dev (input reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
    modport ctl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface

`default_nettype wire

// file: core/dcke_timer.sv
`default_nettype none

module dcke_timer #(
    parameter int TW = 10
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // Load a count, watch it run down
    input  wire logic          load,
    input  wire logic [TW-1:0] value,
    output logic               busy,
    output logic               done
);

    logic [TW-1:0] count_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign busy = (count_reg != '0);
    assign done = (count_reg == TW'(1));

endmodule

`default_nettype wire

// file: core/dcke_device.sv
`include "dcke_cfg.svh"
`default_nettype none

module dcke_device #(
    parameter int TW = `DCKE_TIMER_W
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Command pins from the controller
    dcke_if.dev                        pin,
    // Registered command report
    output logic                       cmd_valid,
    output dcke_pkg::dcke_cmd_e        cmd_code,
    output logic [2:0]                 cmd_bank,
    output logic                       mr_we,
    output logic [1:0]                 mr_sel,
    output logic [`DCKE_ADDR_W-1:0]    mr_data,
    // Device state
    output dcke_pkg::dcke_pwr_e        pwr_state,
    output logic [7:0]                 bank_open,
    output logic                       burst_busy,
    output logic                       refresh_busy,
    output logic                       zq_busy,
    output logic                       io_update,
    output logic                       idle
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic                     dev_arst;
    logic                     cke_prev_reg;
    dcke_pkg::dcke_cmd_e      cmd;
    logic                     is_nop;
    logic                     normal;
    logic                     exe;
    logic                     cke_fall;
    logic                     cke_rise;

    assign dev_arst = rst | ~pin.reset_n;
    assign cmd      = dcke_pkg::dcke_decode({pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n});
    assign is_nop   = (cmd == dcke_pkg::CMD_NOP) || (cmd == dcke_pkg::CMD_DES);
    assign cke_fall = cke_prev_reg & ~pin.cke;
    assign cke_rise = ~cke_prev_reg & pin.cke;
    // Odt is deliberately never read here
    assign normal   = (pwr_state == dcke_pkg::PW_ON) && cke_prev_reg && pin.cke;
    assign exe      = normal && !is_nop;

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            cke_prev_reg <= 1'b1;
        end else begin
            cke_prev_reg <= pin.cke;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timers

    logic          bl8;
    logic [TW-1:0] burst_len;
    logic [2:0]    burst_cnt_reg;
    logic [1:0]    mr0_bl_reg;
    logic          pre_load;
    logic          pre_busy;
    logic          ref_load;
    logic          xp_load;
    logic          xp_busy;
    logic          zq_load;
    logic [TW-1:0] zq_len;
    logic          zq_done;
    logic          zq_first_reg;
    logic          auto_pre;

    assign bl8 = (mr0_bl_reg == `DCKE_BL_FIXED8) ||
                 ((mr0_bl_reg == `DCKE_BL_OTF) && pin.addr[`DCKE_A12]);
    assign burst_len = bl8 ? TW'(`DCKE_BL8_CYC) : TW'(`DCKE_BC4_CYC);
    assign auto_pre  = exe && pin.addr[`DCKE_A10] &&
                       (cmd == dcke_pkg::CMD_RD || cmd == dcke_pkg::CMD_WR);
    assign pre_load  = (exe && cmd == dcke_pkg::CMD_PRE) || auto_pre;
    assign ref_load  = exe && cmd == dcke_pkg::CMD_REF && pin.cke;
    assign zq_load   = exe && cmd == dcke_pkg::CMD_ZQ && !zq_busy;
    assign zq_len    = !pin.addr[`DCKE_A10] ? TW'(`DCKE_ZQCS_CYC) :
                       zq_first_reg ? TW'(`DCKE_ZQINIT_CYC) : TW'(`DCKE_ZQOPER_CYC);

    dcke_timer #(.TW(TW)) u_pre (
        .mclk  (mclk),
        .rst   (dev_arst),
        .load  (pre_load),
        .value (auto_pre ? TW'(burst_len + TW'(`DCKE_T_RP_CYC)) : TW'(`DCKE_T_RP_CYC)),
        .busy  (pre_busy),
        .done  ()
    );

    dcke_timer #(.TW(TW)) u_ref (
        .mclk  (mclk),
        .rst   (dev_arst),
        .load  (ref_load),
        .value (TW'(`DCKE_T_RFC_CYC)),
        .busy  (refresh_busy),
        .done  ()
    );

    dcke_timer #(.TW(TW)) u_xp (
        .mclk  (mclk),
        .rst   (dev_arst),
        .load  (xp_load),
        .value (TW'(`DCKE_T_XP_CYC)),
        .busy  (xp_busy),
        .done  ()
    );

    dcke_timer #(.TW(TW)) u_zq (
        .mclk  (mclk),
        .rst   (dev_arst),
        .load  (zq_load),
        .value (zq_len),
        .busy  (zq_busy),
        .done  (zq_done)
    );

    // A new read or write during a burst is not a way to cut it short
    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            burst_cnt_reg <= 3'h0;
        end else if (burst_cnt_reg != 3'h0) begin
            burst_cnt_reg <= burst_cnt_reg - 3'h1;
        end else if (exe && (cmd == dcke_pkg::CMD_RD || cmd == dcke_pkg::CMD_WR)) begin
            burst_cnt_reg <= burst_len[2:0];
        end
    end
    assign burst_busy = (burst_cnt_reg != 3'h0);

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            zq_first_reg <= 1'b1;
        end else if (zq_load && pin.addr[`DCKE_A10]) begin
            zq_first_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            io_update <= 1'b0;
        end else begin
            io_update <= zq_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Banks and mode register 0

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            bank_open <= 8'h00;
        end else if (exe && cmd == dcke_pkg::CMD_ACT) begin
            bank_open[pin.ba] <= 1'b1;
        end else if (exe && cmd == dcke_pkg::CMD_PRE && pin.addr[`DCKE_A10]) begin
            bank_open <= 8'h00;
        end else if (pre_load) begin
            bank_open[pin.ba] <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            mr0_bl_reg <= `DCKE_BL_FIXED8;
        end else if (exe && cmd == dcke_pkg::CMD_MRS && pin.ba[1:0] == 2'h0) begin
            mr0_bl_reg <= pin.addr[`DCKE_MR0_BL_LSB +: 2];
        end
    end

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            cmd_valid <= 1'b0;
            cmd_code  <= dcke_pkg::CMD_DES;
            cmd_bank  <= 3'h0;
            mr_we     <= 1'b0;
            mr_sel    <= 2'h0;
            mr_data   <= '0;
        end else begin
            cmd_valid <= exe;
            cmd_code  <= normal ? cmd : dcke_pkg::CMD_DES;
            cmd_bank  <= pin.ba;
            mr_we     <= exe && cmd == dcke_pkg::CMD_MRS;
            mr_sel    <= pin.ba[1:0];
            mr_data   <= pin.addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state

    logic sr_flag_reg;
    logic sr_clr;
    logic sr_entry;

    assign idle = (pwr_state == dcke_pkg::PW_ON) && bank_open == 8'h00 && !burst_busy &&
                  !pre_busy && !refresh_busy && !xp_busy && !zq_busy && cke_prev_reg;
    assign sr_entry = idle && cke_fall && cmd == dcke_pkg::CMD_REF;

    // Cke high clears the flag without any clock edge
    assign sr_clr = dev_arst | pin.cke;

    always_ff @(posedge mclk or posedge sr_clr) begin
        if (sr_clr) begin
            sr_flag_reg <= 1'b0;
        end else if (sr_entry) begin
            sr_flag_reg <= 1'b1;
        end
    end

    assign xp_load = (pwr_state != dcke_pkg::PW_ON) && cke_rise && is_nop;

    always_ff @(posedge mclk or posedge dev_arst) begin
        if (dev_arst) begin
            pwr_state <= dcke_pkg::PW_ON;
        end else begin
            unique case (pwr_state)
                dcke_pkg::PW_ON: begin
                    if (sr_entry) begin
                        pwr_state <= dcke_pkg::PW_SR;
                    end else if (cke_fall && is_nop) begin
                        if (burst_busy || pre_busy) begin
                            pwr_state <= dcke_pkg::PW_PD;
                        end else if (refresh_busy || bank_open == 8'h00) begin
                            pwr_state <= dcke_pkg::PW_PPD;
                        end else begin
                            pwr_state <= dcke_pkg::PW_APD;
                        end
                    end
                end
                dcke_pkg::PW_SR: begin
                    if (!sr_flag_reg) begin
                        pwr_state <= dcke_pkg::PW_ON;
                    end
                end
                default: begin
                    // Commands are ignored while cke stays low
                    if (cke_rise && is_nop) begin
                        pwr_state <= dcke_pkg::PW_ON;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: core/dcke_ctrl.sv
`include "dcke_cfg.svh"
`default_nettype none

module dcke_ctrl #(
    parameter int TW = `DCKE_TIMER_W
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // User command request
    input  wire logic                  req_valid,
    input  wire dcke_pkg::dcke_cmd_e   req_cmd,
    input  wire logic [2:0]            req_ba,
    input  wire logic [`DCKE_ADDR_W-1:0] req_addr,
    output logic                       req_ready,
    // Low power requests, held as levels
    input  wire logic                  pd_req,
    input  wire logic                  sr_req,
    output logic                       low_power,
    output logic                       init_done,
    // Pins toward the device
    dcke_if.ctl                        pin
);

    typedef enum logic [1:0] {C_INIT, C_ON, C_LOW} dcke_cst_e;

    dcke_cst_e     st_reg;
    logic [7:0]    open_reg;
    logic          ref_owed_reg;
    logic          wait_load;
    logic [TW-1:0] wait_len;
    logic          wait_busy;
    logic          sr_ok;
    logic [TW-1:0] burst_wait;

    dcke_timer #(.TW(TW)) u_wait (
        .mclk  (mclk),
        .rst   (rst),
        .load  (wait_load),
        .value (wait_len),
        .busy  (wait_busy),
        .done  ()
    );

    assign sr_ok      = (open_reg == 8'h00);
    assign req_ready  = (st_reg == C_ON) && !wait_busy && !ref_owed_reg && !sr_req && !pd_req;
    assign low_power  = (st_reg == C_LOW);
    assign init_done  = (st_reg != C_INIT);
    // Worst case burst plus recovery, so nothing lands inside a burst
    assign burst_wait = TW'(`DCKE_BL8_CYC + `DCKE_T_RP_CYC);

    always_comb begin
        wait_load = 1'b0;
        wait_len  = TW'(1);
        if (!wait_busy) begin
            unique case (st_reg)
                C_INIT: begin
                    wait_load = 1'b1;
                    wait_len  = TW'(`DCKE_ZQINIT_CYC);
                end
                C_LOW: begin
                    wait_load = !pd_req && !sr_req;
                    wait_len  = TW'(`DCKE_T_CKE_CYC + `DCKE_T_XP_CYC);
                end
                C_ON: begin
                    if (ref_owed_reg) begin
                        wait_load = 1'b1;
                        wait_len  = TW'(`DCKE_T_RFC_CYC);
                    end else if ((sr_req && sr_ok) || pd_req) begin
                        wait_load = 1'b1;
                        wait_len  = TW'(`DCKE_T_CKE_CYC);
                    end else if (req_valid && req_ready) begin
                        wait_load = 1'b1;
                        unique case (req_cmd)
                            dcke_pkg::CMD_ZQ:  wait_len = req_addr[`DCKE_A10] ?
                                TW'(`DCKE_ZQOPER_CYC) : TW'(`DCKE_ZQCS_CYC);
                            dcke_pkg::CMD_REF: wait_len = TW'(`DCKE_T_RFC_CYC);
                            dcke_pkg::CMD_RD,
                            dcke_pkg::CMD_WR:  wait_len = burst_wait;
                            default:           wait_len = TW'(`DCKE_T_RP_CYC);
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin.reset_n <= 1'b0;
        end else begin
            pin.reset_n <= 1'b1;
        end
    end

    // Pins; every wait cycle sends NOP
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg       <= C_INIT;
            ref_owed_reg <= 1'b0;
            open_reg     <= 8'h00;
            pin.cke      <= 1'b1;
            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <= dcke_pkg::dcke_encode(dcke_pkg::CMD_NOP);
            pin.odt      <= 1'b0;
            pin.ba       <= 3'h0;
            pin.addr     <= '0;
        end else begin
            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <=
                dcke_pkg::dcke_encode(dcke_pkg::CMD_NOP);
            if (wait_load) begin
                unique case (st_reg)
                    C_INIT: begin
                        {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <=
                            dcke_pkg::dcke_encode(dcke_pkg::CMD_ZQ);
                        pin.addr <= '0;
                        pin.addr[`DCKE_A10] <= 1'b1;
                        st_reg <= C_ON;
                    end
                    C_LOW: begin
                        pin.cke <= 1'b1;
                        st_reg  <= C_ON;
                    end
                    C_ON: begin
                        if (ref_owed_reg) begin
                            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <=
                                dcke_pkg::dcke_encode(dcke_pkg::CMD_REF);
                            ref_owed_reg <= 1'b0;
                        end else if (sr_req && sr_ok) begin
                            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <=
                                dcke_pkg::dcke_encode(dcke_pkg::CMD_REF);
                            pin.cke <= 1'b0;
                            st_reg  <= C_LOW;
                        end else if (pd_req) begin
                            pin.cke      <= 1'b0;
                            ref_owed_reg <= 1'b1;
                            st_reg       <= C_LOW;
                        end else begin
                            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <=
                                dcke_pkg::dcke_encode(req_cmd);
                            pin.ba   <= req_ba;
                            pin.addr <= req_addr;
                            if (req_cmd == dcke_pkg::CMD_ACT) begin
                                open_reg[req_ba] <= 1'b1;
                            end else if (req_cmd == dcke_pkg::CMD_PRE) begin
                                if (req_addr[`DCKE_A10]) begin
                                    open_reg <= 8'h00;
                                end else begin
                                    open_reg[req_ba] <= 1'b0;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: dv/dcke_asserts.sv
`default_nettype none

module dcke_asserts (
    // Clock and reset
    input wire logic                mclk,
    input wire logic                rst,
    // Link pins
    input wire logic                reset_n,
    input wire logic                cke,
    input wire logic                cs_n,
    input wire logic                ras_n,
    input wire logic                cas_n,
    input wire logic                we_n,
    input wire logic [2:0]          ba,
    input wire logic [13:0]         addr,
    // Device reports
    input wire logic                cmd_valid,
    input wire dcke_pkg::dcke_pwr_e pwr_state,
    input wire logic [7:0]          bank_open,
    input wire logic                burst_busy,
    input wire logic                io_update
);
    logic [9:0] since_reg;
    logic       cke_q_reg;
    wire  [3:0] pat   = {cs_n, ras_n, cas_n, we_n};
    wire        quiet = cs_n || pat == 4'h7;
    wire        on    = pwr_state == dcke_pkg::PW_ON;
    wire        take  = cke && cke_q_reg && on;

    // Saturates so the init window is judged once per reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            since_reg <= 10'h000;
        end else if (since_reg != 10'h3ff) begin
            since_reg <= since_reg + 10'h001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cke_q_reg <= 1'b1;
        end else begin
            cke_q_reg <= cke;
        end
    end

    default clocking dcke_cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_pin_high: assert property (since_reg != 10'h000 |-> reset_n)
        else $error("reset pin low in operation");
    a_init_zq_long: assert property (since_reg == 10'h001 |-> pat == 4'h6 && addr[10])
        else $error("no long calibration after reset");
    a_init_window_quiet: assert property (
        since_reg >= 10'h002 && since_reg <= 10'h200 |-> quiet)
        else $error("command inside init calibration window");
    a_cke_hold: assert property ($changed(cke) |=> $stable(cke) [*2])
        else $error("clock enable pulse too short");
    a_cke_edge_cmd: assert property (
        $changed(cke) |-> quiet || (!cke && pat == 4'h1))
        else $error("illegal command at clock enable change");
    a_quiet_no_exec: assert property (quiet |=> !cmd_valid)
        else $error("nop or deselect executed");
    a_lowpwr_hold: assert property (!on && !cke && !cke_q_reg |=> $stable(pwr_state))
        else $error("low power state left with enable low");
    a_sr_entry: assert property (
        $fell(cke) && pat == 4'h1 && on && bank_open == 8'h00 |=> pwr_state == dcke_pkg::PW_SR)
        else $error("self refresh not entered");
    a_lowpwr_exit: assert property ($rose(cke) && !on |=> on)
        else $error("low power not left");
    a_act_bank: assert property (take && pat == 4'h3 |=> bank_open[$past(ba)])
        else $error("activated bank not open");
    a_burst_runs: assert property (
        take && (pat == 4'h5 || pat == 4'h4) |=> burst_busy [*4])
        else $error("burst cut short");
    a_zq_long_update: assert property (
        take && pat == 4'h6 && addr[10] |-> ##[1:600] io_update)
        else $error("calibration result never applied");
endmodule

`default_nettype wire

// file: dv/tb_sdram_cke_command_state_control.sv
`default_nettype none

module tb_sdram_cke_command_state_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic                mclk      = 1'b0;
    logic                rst       = 1'b1;
    logic                req_valid = 1'b0;
    dcke_pkg::dcke_cmd_e req_cmd   = dcke_pkg::CMD_NOP;
    logic [2:0]          req_ba    = 3'h0;
    logic [13:0]         req_addr  = 14'h0000;
    logic                pd_req    = 1'b0;
    logic                sr_req    = 1'b0;
    wire                 req_ready, low_power, init_done, cmd_valid, mr_we;
    wire                 burst_busy, refresh_busy, zq_busy, io_update, idle;
    dcke_pkg::dcke_cmd_e cmd_code;
    dcke_pkg::dcke_pwr_e pwr_state;
    wire [2:0]           cmd_bank;
    wire [1:0]           mr_sel;
    wire [13:0]          mr_data;
    wire [7:0]           bank_open;
    int                  n_fail      = 0;
    int                  comparisons = 0;
    int                  cyc         = 0;

    dcke_if #(.AW(14)) dcke_if_i ();
    dcke_ctrl dcke_ctrl_i (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_ba(req_ba), .req_addr(req_addr), .req_ready(req_ready), .pd_req(pd_req),
        .sr_req(sr_req), .low_power(low_power), .init_done(init_done), .pin(dcke_if_i));
    dcke_device dcke_device_i (.mclk(mclk), .rst(rst), .pin(dcke_if_i), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_bank(cmd_bank), .mr_we(mr_we), .mr_sel(mr_sel),
        .mr_data(mr_data), .pwr_state(pwr_state), .bank_open(bank_open),
        .burst_busy(burst_busy), .refresh_busy(refresh_busy), .zq_busy(zq_busy),
        .io_update(io_update), .idle(idle));
    dcke_asserts dcke_asserts_i (.mclk(mclk), .rst(rst), .reset_n(dcke_if_i.reset_n),
        .cke(dcke_if_i.cke), .cs_n(dcke_if_i.cs_n), .ras_n(dcke_if_i.ras_n),
        .cas_n(dcke_if_i.cas_n), .we_n(dcke_if_i.we_n), .ba(dcke_if_i.ba),
        .addr(dcke_if_i.addr), .cmd_valid(cmd_valid), .pwr_state(pwr_state),
        .bank_open(bank_open), .burst_busy(burst_busy), .io_update(io_update));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 mclk = ~mclk;
    end

    // Whole run is about 1500 cycles; ceiling leaves margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered and left at a falling edge; ready is stable there
    task automatic issue(input dcke_pkg::dcke_cmd_e c, input logic [2:0] b,
                         input logic [13:0] a);
        for (int i = 0; i < 600 && req_ready !== 1'b1; i++) @(negedge mclk);
        req_valid = 1'b1;
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        @(negedge mclk);
        req_valid = 1'b0;
    endtask

    task automatic t_init();
        int n;
        for (n = 0; n < 700 && req_ready !== 1'b1; n++) @(negedge mclk);
        chk(n >= 512, 1'b1);
        chk(init_done, 1'b1);
        $display("test init done");
    endtask

    task automatic t_cmds();
        issue(dcke_pkg::CMD_ACT, 3'h5, 14'h0000);
        repeat (3) @(negedge mclk);
        chk(bank_open, 8'h20);
        issue(dcke_pkg::CMD_MRS, 3'h2, 14'h0123);
        @(negedge mclk);
        chk(mr_we, 1'b1);
        chk(mr_sel, 2'h2);
        chk(mr_data, 14'h0123);
        issue(dcke_pkg::CMD_WR, 3'h5, 14'h0000);
        issue(dcke_pkg::CMD_RD, 3'h5, 14'h0000);
        issue(dcke_pkg::CMD_ZQ, 3'h0, 14'h0000);
        issue(dcke_pkg::CMD_ZQ, 3'h0, 14'h0400);
        @(negedge mclk);
        chk(zq_busy, 1'b1);
        for (int i = 0; i < 600 && req_ready !== 1'b1; i++) @(negedge mclk);
        chk(bank_open, 8'h20);
        $display("test commands done");
    endtask

    task automatic t_lowpower(input logic sr, input dcke_pkg::dcke_pwr_e exp);
        pd_req = !sr;
        sr_req = sr;
        for (int i = 0; i < 50 && low_power !== 1'b1; i++) @(negedge mclk);
        repeat (4) @(negedge mclk);
        chk(pwr_state, exp);
        chk(refresh_busy, 1'b0);
        pd_req = 1'b0;
        sr_req = 1'b0;
        for (int i = 0; i < 50 && low_power !== 1'b0; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        chk(pwr_state, dcke_pkg::PW_ON);
        for (int i = 0; i < 30 && refresh_busy !== 1'b1; i++) @(negedge mclk);
        if (!sr) chk(refresh_busy, 1'b1);
        $display("test low power done");
    endtask

    task automatic t_reset();
        issue(dcke_pkg::CMD_ACT, 3'h1, 14'h0000);
        repeat (3) @(negedge mclk);
        chk(bank_open, 8'h02);
        rst = 1'b1;
        @(negedge mclk);
        chk(bank_open, 8'h00);
        chk(pwr_state, dcke_pkg::PW_ON);
        rst = 1'b0;
        t_init();
        $display("test reset done");
    endtask

    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_init();
        t_cmds();
        t_lowpower(1'b0, dcke_pkg::PW_APD);
        issue(dcke_pkg::CMD_PRE, 3'h0, 14'h0400);
        for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge mclk);
        chk(bank_open, 8'h00);
        @(negedge mclk);
        chk(idle, 1'b1);
        t_lowpower(1'b0, dcke_pkg::PW_PPD);
        t_lowpower(1'b1, dcke_pkg::PW_SR);
        t_reset();
        test_done();
    end
endmodule

`default_nettype wire
